// ===== rtl/meas_readback.sv
// Overview of operation
// R1 - Phase A current readable as a 32-bit read-only word, amperes equal word/2^27*1.25.
// R2 - Phase B current readable as a 32-bit read-only word, same scaling.
// R3 - Phase C current readable as a 32-bit read-only word, same scaling.
// R4 - Sense gain field in low 16 bits: codes 0..3 mean 1.2, 0.6, 0.3, 0.15 V/A.
// R5 - Phase A current reads zero after reset until the first measurement.
// R6 - Voltage gain field in low 16 bits: codes 0..2 mean 60, 30, 15 V.
// R7 - Writes to measurement readback registers are ignored and change nothing.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps

module meas_readback
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic ARST_N,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Phase current samples from the measurement path.
    input wire logic [31:0] PHASE_A_VALUE,
    input wire logic PHASE_A_UPDATE,
    input wire logic [31:0] PHASE_B_VALUE,
    input wire logic PHASE_B_UPDATE,
    input wire logic [31:0] PHASE_C_VALUE,
    input wire logic PHASE_C_UPDATE,
    // Active gain settings from the configuration path.
    input wire logic [1:0] SENSE_GAIN_CODE,
    input wire logic SENSE_GAIN_LOAD,
    input wire logic [1:0] VOLT_GAIN_CODE,
    input wire logic VOLT_GAIN_LOAD
);

    // ******************************************************************
    // State
    // ******************************************************************

    typedef struct packed
    {
        logic [31:0] rdata;
        logic slverr;
        logic freeze;
        logic [2:0] seen;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    logic [2:0][31:0] sample_in;
    logic [2:0] sample_strobe;
    logic [2:0] phase_take;
    logic [2:0][31:0] current_word;
    logic [15:0] sense_gain_field;
    logic [15:0] volt_gain_field;
    logic setup_phase;
    logic access_write;

    // ******************************************************************
    // Measurement storage
    // ******************************************************************

    // The three phases share one latch design, indexed A, B, C from zero.
    assign sample_in = {PHASE_C_VALUE, PHASE_B_VALUE, PHASE_A_VALUE};
    assign sample_strobe = {PHASE_C_UPDATE, PHASE_B_UPDATE, PHASE_A_UPDATE};

    // R1 R2 R3 phase words held.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_phase
            assign phase_take[gi] = sample_strobe[gi] && !state_ff.freeze;

            meas_word_latch u_latch
            (
                .clock(CLOCK),
                .arst_n(ARST_N),
                .sample_value(sample_in[gi]),
                .sample_strobe(sample_strobe[gi]),
                .hold(state_ff.freeze),
                .word(current_word[gi])
            );
        end
    endgenerate

    // R4 sense gain field.
    gain_code_latch
    #(
        .LAST_CODE(meas_readback_pkg::SENSE_GAIN_LAST)
    )
    u_sense_gain
    (
        .clock(CLOCK),
        .arst_n(ARST_N),
        .code_in(SENSE_GAIN_CODE),
        .code_load(SENSE_GAIN_LOAD),
        .field(sense_gain_field)
    );

    // R6 voltage gain field, code three dropped.
    gain_code_latch
    #(
        .LAST_CODE(meas_readback_pkg::VOLT_GAIN_LAST)
    )
    u_volt_gain
    (
        .clock(CLOCK),
        .arst_n(ARST_N),
        .code_in(VOLT_GAIN_CODE),
        .code_load(VOLT_GAIN_LOAD),
        .field(volt_gain_field)
    );

    // ******************************************************************
    // APB decode
    // ******************************************************************

    // Read data is captured in the setup cycle so that it comes from a flop;
    // the cost is that an update landing in the access cycle shows next read.
    assign setup_phase = PSEL && !PENABLE;
    assign access_write = PSEL && PENABLE && PWRITE;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.seen = state_ff.seen | phase_take;
        if (setup_phase)
        begin
            nxt_state.slverr = 1'b0;
            nxt_state.rdata = meas_readback_pkg::RDATA_RESET;
            unique case (PADDR)
                meas_readback_pkg::ADDR_PHASE_A:
                begin
                    nxt_state.rdata = current_word[0];
                end
                meas_readback_pkg::ADDR_PHASE_B:
                begin
                    nxt_state.rdata = current_word[1];
                end
                meas_readback_pkg::ADDR_PHASE_C:
                begin
                    nxt_state.rdata = current_word[2];
                end
                meas_readback_pkg::ADDR_SENSE_GAIN:
                begin
                    nxt_state.rdata = {16'h0, sense_gain_field};
                end
                meas_readback_pkg::ADDR_VOLT_GAIN:
                begin
                    nxt_state.rdata = {16'h0, volt_gain_field};
                end
                meas_readback_pkg::ADDR_CONTROL:
                begin
                    nxt_state.rdata = {31'h0, state_ff.freeze};
                end
                default:
                begin
                    nxt_state.slverr = 1'b1;
                end
            endcase
        end
        // R7 readback writes ignored.
        if (access_write && (PADDR == meas_readback_pkg::ADDR_CONTROL))
        begin
            nxt_state.freeze = PWDATA[meas_readback_pkg::FREEZE_BIT];
        end
    end

    // Registered state.
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_ff <= '{rdata: meas_readback_pkg::RDATA_RESET,
                          slverr: 1'b0,
                          freeze: meas_readback_pkg::FREEZE_RESET,
                          seen: 3'h0};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Every access completes in its first access cycle.
    assign PREADY = 1'b1;
    assign PRDATA = state_ff.rdata;
    assign PSLVERR = state_ff.slverr;

    // ******************************************************************
    // Checks
    // ******************************************************************

    // R1 phase A readback.
    chk_phase_a_read: // R1
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (setup_phase && (PADDR == meas_readback_pkg::ADDR_PHASE_A))
        |=> (PRDATA == $past(current_word[0])) && !PSLVERR)
    else $error("Phase A read returned wrong data.");

    // R2 phase B readback.
    chk_phase_b_read: // R2
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (setup_phase && (PADDR == meas_readback_pkg::ADDR_PHASE_B))
        |=> (PRDATA == $past(current_word[1])) && !PSLVERR)
    else $error("Phase B read returned wrong data.");

    // R3 phase C sample.
    chk_phase_c_take: // R3
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        phase_take[2] |=> (current_word[2] == $past(PHASE_C_VALUE)))
    else $error("Phase C sample was not stored.");

    // R4 sense gain readback.
    chk_sense_gain_read: // R4
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (setup_phase && (PADDR == meas_readback_pkg::ADDR_SENSE_GAIN))
        |=> (PRDATA == {16'h0, $past(sense_gain_field)}))
    else $error("Sense gain read returned wrong data.");

    // R5 zero before measurement.
    chk_phase_a_zero: // R5
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        !state_ff.seen[0] |-> (current_word[0] == meas_readback_pkg::MEAS_RESET))
    else $error("Phase A nonzero before first measurement.");

    // R6 voltage gain range.
    chk_volt_gain_code: // R6
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        volt_gain_field <= {14'h0, meas_readback_pkg::VOLT_GAIN_LAST})
    else $error("Voltage gain field holds an illegal code.");

    // R7 writes leave words.
    chk_write_ignored: // R7
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (access_write && !(|phase_take)) |=> $stable(current_word))
    else $error("Measurement word changed without an update.");

    // Control readback follows the freeze bit.
    chk_control_read:
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (setup_phase && (PADDR == meas_readback_pkg::ADDR_CONTROL))
        |=> (PRDATA == {31'h0, $past(state_ff.freeze)}))
    else $error("Control read returned wrong data.");

    // R1 phase A sample.
    chk_phase_a_take: // R1
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        phase_take[0] |=> (current_word[0] == $past(PHASE_A_VALUE)))
    else $error("Phase A sample was not stored.");

    // R2 phase B sample.
    chk_phase_b_take: // R2
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        phase_take[1] |=> (current_word[1] == $past(PHASE_B_VALUE)))
    else $error("Phase B sample was not stored.");

    // R3 phase C readback.
    chk_phase_c_read: // R3
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (setup_phase && (PADDR == meas_readback_pkg::ADDR_PHASE_C))
        |=> (PRDATA == $past(current_word[2])) && !PSLVERR)
    else $error("Phase C read returned wrong data.");

    // R4 sense gain load; every code is legal, so none may be dropped.
    chk_sense_gain_load: // R4
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        SENSE_GAIN_LOAD |=> (sense_gain_field == {14'h0, $past(SENSE_GAIN_CODE)}))
    else $error("Sense gain code was not loaded.");

    // R6 voltage gain readback.
    chk_volt_gain_read: // R6
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (setup_phase && (PADDR == meas_readback_pkg::ADDR_VOLT_GAIN))
        |=> (PRDATA == {16'h0, $past(volt_gain_field)}) && !PSLVERR)
    else $error("Voltage gain read returned wrong data.");

    // R6 illegal code dropped.
    chk_volt_gain_drop: // R6
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (VOLT_GAIN_LOAD && (VOLT_GAIN_CODE > meas_readback_pkg::VOLT_GAIN_LAST))
        |=> $stable(volt_gain_field))
    else $error("Voltage gain field took an illegal code.");

    // A frozen set must not move, or software would read a torn snapshot.
    chk_frozen_hold:
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        state_ff.freeze |=> $stable(current_word))
    else $error("Measurement word changed while frozen.");

    // Read data and error stand until the next setup cycle.
    chk_read_data_stands:
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        !setup_phase |=> ($stable(PRDATA) && $stable(PSLVERR)))
    else $error("Read data changed outside a setup cycle.");

    // A control write lands in the freeze bit.
    chk_control_write:
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (access_write && (PADDR == meas_readback_pkg::ADDR_CONTROL))
        |=> (state_ff.freeze == $past(PWDATA[meas_readback_pkg::FREEZE_BIT])))
    else $error("Control write did not reach the freeze bit.");

endmodule

// ===== rtl/meas_readback_pkg.sv
package meas_readback_pkg;

    // ******************************************************************
    // Bus and field widths
    // ******************************************************************
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FIELD_W = 16;
    localparam int unsigned GAIN_W = 2;
    localparam int unsigned NUM_PHASES = 3;

    // ******************************************************************
    // Register indices; the byte address is four times the index
    // ******************************************************************
    localparam logic [11:0] IDX_PHASE_A = 12'h43e;
    localparam logic [11:0] IDX_PHASE_B = 12'h440;
    localparam logic [11:0] IDX_PHASE_C = 12'h442;
    localparam logic [11:0] IDX_SENSE_GAIN = 12'h466;
    localparam logic [11:0] IDX_VOLT_GAIN = 12'h476;
    localparam logic [11:0] IDX_CONTROL = 12'h490;

    localparam logic [15:0] ADDR_PHASE_A = {2'h0, IDX_PHASE_A, 2'h0};
    localparam logic [15:0] ADDR_PHASE_B = {2'h0, IDX_PHASE_B, 2'h0};
    localparam logic [15:0] ADDR_PHASE_C = {2'h0, IDX_PHASE_C, 2'h0};
    localparam logic [15:0] ADDR_SENSE_GAIN = {2'h0, IDX_SENSE_GAIN, 2'h0};
    localparam logic [15:0] ADDR_VOLT_GAIN = {2'h0, IDX_VOLT_GAIN, 2'h0};
    localparam logic [15:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};

    // ******************************************************************
    // Field positions, legal codes and reset values
    // ******************************************************************
    localparam int unsigned FREEZE_BIT = 0;
    localparam logic [1:0] SENSE_GAIN_LAST = 2'h3;
    localparam logic [1:0] VOLT_GAIN_LAST = 2'h2;
    localparam logic [31:0] MEAS_RESET = 32'h0;
    localparam logic [1:0] GAIN_RESET = 2'h0;
    localparam logic FREEZE_RESET = 1'b0;
    localparam logic [31:0] RDATA_RESET = 32'h0;

endpackage

// ===== rtl/meas_word_latch.sv
`timescale 1ns/10ps

module meas_word_latch
(
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // New sample from the measurement path.
    input wire logic [31:0] sample_value,
    input wire logic sample_strobe,
    input wire logic hold,
    // Stored word.
    output logic [31:0] word
);

    typedef struct packed
    {
        logic [31:0] word;
    } latch_state_t;

    latch_state_t state_ff;
    latch_state_t nxt_state;

    // A sample is taken only while software does not hold the set steady.
    always_comb
    begin
        nxt_state = state_ff;
        if (sample_strobe && !hold)
        begin
            nxt_state.word = sample_value;
        end
    end

    // The word starts at zero until the first sample arrives.
    // R5 zero after reset.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= '{word: meas_readback_pkg::MEAS_RESET};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign word = state_ff.word;

endmodule

// ===== rtl/gain_code_latch.sv
`timescale 1ns/10ps

module gain_code_latch
#(
    parameter logic [1:0] LAST_CODE = 2'h3
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Active gain setting from the configuration path.
    input wire logic [1:0] code_in,
    input wire logic code_load,
    // Readback field, zero above the code.
    output logic [15:0] field
);

    typedef struct packed
    {
        logic [1:0] code;
    } gain_state_t;

    gain_state_t state_ff;
    gain_state_t nxt_state;

    // A code beyond the last legal one is dropped, so the field never shows it.
    always_comb
    begin
        nxt_state = state_ff;
        if (code_load && (code_in <= LAST_CODE))
        begin
            nxt_state.code = code_in;
        end
    end

    // Registered code.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= '{code: meas_readback_pkg::GAIN_RESET};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign field = {14'h0, state_ff.code};

endmodule

// ===== test/meas_readback_bench.sv
`timescale 1ns/10ps

module meas_readback_bench;

    // ********************************
    // Bench signals
    // ********************************
    logic clock;
    logic arst_n;
    logic psel, penable, pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    logic [31:0] val_a, val_b, val_c;
    logic upd_a, upd_b, upd_c;
    logic [1:0] sg_code, vg_code;
    logic sg_load, vg_load;
    int fails;
    int num_checks;

    meas_readback u_meas_readback
    (
        .CLOCK(clock), .ARST_N(arst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PHASE_A_VALUE(val_a), .PHASE_A_UPDATE(upd_a),
        .PHASE_B_VALUE(val_b), .PHASE_B_UPDATE(upd_b),
        .PHASE_C_VALUE(val_c), .PHASE_C_UPDATE(upd_c),
        .SENSE_GAIN_CODE(sg_code), .SENSE_GAIN_LOAD(sg_load),
        .VOLT_GAIN_CODE(vg_code), .VOLT_GAIN_LOAD(vg_load)
    );

    // A 40 ns period gives the 25 MHz system clock.
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // The request is held until PREADY is sampled; no wait count is assumed.
    task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wd,
                          input logic [31:0] exp, input logic exp_err, input string what);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        if (!wr)
            check(what, exp, prdata);
        check({what, " slverr"}, {31'h0, exp_err}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Measurement strobes change one edge at a time, so back-to-back pulses work.
    task automatic sample(input logic [2:0] which, input logic [31:0] a, b, c);
        @(posedge clock);
        {upd_c, upd_b, upd_a} <= which;
        val_a <= a;
        val_b <= b;
        val_c <= c;
    endtask

    task automatic gain(input logic [1:0] sc, input logic sl, input logic [1:0] vc,
                        input logic vl);
        @(posedge clock);
        sg_code <= sc;
        sg_load <= sl;
        vg_code <= vc;
        vg_load <= vl;
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic test_reset();
        access(1'b0, meas_readback_pkg::ADDR_PHASE_A, 32'h0, 32'h0, 1'b0, "a rst");
        access(1'b0, meas_readback_pkg::ADDR_PHASE_B, 32'h0, 32'h0, 1'b0, "b rst");
        access(1'b0, meas_readback_pkg::ADDR_PHASE_C, 32'h0, 32'h0, 1'b0, "c rst");
        access(1'b0, meas_readback_pkg::ADDR_SENSE_GAIN, 32'h0, 32'h0, 1'b0, "sg rst");
        access(1'b0, meas_readback_pkg::ADDR_VOLT_GAIN, 32'h0, 32'h0, 1'b0, "vg rst");
    endtask

    // Phase A gets two pulses in a row; only the later value may stay.
    task automatic test_phases();
        sample(3'h7, 32'h0a5a5a51, 32'hfff00002, 32'h80000003);
        sample(3'h1, 32'h7ffffffe, 32'h11111111, 32'h22222222);
        sample(3'h0, 32'h33333333, 32'h44444444, 32'h55555555);
        access(1'b0, meas_readback_pkg::ADDR_PHASE_A, 32'h0, 32'h7ffffffe, 1'b0, "a");
        access(1'b0, meas_readback_pkg::ADDR_PHASE_B, 32'h0, 32'hfff00002, 1'b0, "b");
        access(1'b0, meas_readback_pkg::ADDR_PHASE_C, 32'h0, 32'h80000003, 1'b0, "c");
    endtask

    task automatic test_gains();
        for (int c = 0; c < 4; c++)
        begin
            gain(2'(c), 1'b1, 2'h0, 1'b0);
            gain(2'h0, 1'b0, 2'h0, 1'b0);
            access(1'b0, meas_readback_pkg::ADDR_SENSE_GAIN, 32'h0, 32'(c), 1'b0, "sg");
        end
        // Code 3 has no voltage range, so the field keeps the last legal code.
        for (int c = 0; c < 4; c++)
        begin
            gain(2'h0, 1'b0, 2'(c), 1'b1);
            gain(2'h0, 1'b0, 2'h0, 1'b0);
            access(1'b0, meas_readback_pkg::ADDR_VOLT_GAIN, 32'h0, (c > 2) ? 32'h2 : 32'(c),
                   1'b0, "vg");
        end
    endtask

    // Writes to the five readback words complete without error but must leave every readback word as it was.
    task automatic test_writes();
        access(1'b1, meas_readback_pkg::ADDR_PHASE_A, 32'hffffffff, 32'h0, 1'b0, "wa");
        access(1'b1, meas_readback_pkg::ADDR_PHASE_B, 32'h5a5a5a5a, 32'h0, 1'b0, "wb");
        access(1'b1, meas_readback_pkg::ADDR_PHASE_C, 32'h0, 32'h0, 1'b0, "wc");
        access(1'b1, meas_readback_pkg::ADDR_SENSE_GAIN, 32'h0, 32'h0, 1'b0, "wsg");
        access(1'b1, meas_readback_pkg::ADDR_VOLT_GAIN, 32'h1, 32'h0, 1'b0, "wvg");
        access(1'b0, meas_readback_pkg::ADDR_PHASE_A, 32'h0, 32'h7ffffffe, 1'b0, "a");
        access(1'b0, meas_readback_pkg::ADDR_PHASE_B, 32'h0, 32'hfff00002, 1'b0, "b");
        access(1'b0, meas_readback_pkg::ADDR_PHASE_C, 32'h0, 32'h80000003, 1'b0, "c");
        access(1'b0, meas_readback_pkg::ADDR_SENSE_GAIN, 32'h0, 32'h3, 1'b0, "sg");
        access(1'b0, meas_readback_pkg::ADDR_VOLT_GAIN, 32'h0, 32'h2, 1'b0, "vg");
        access(1'b0, 16'h1104, 32'h0, 32'h0, 1'b1, "hole");
        access(1'b1, 16'h10f9, 32'h5, 32'h0, 1'b1, "misaligned");
    endtask

    // While frozen a phase pulse is lost; after thawing it is stored again.
    task automatic test_freeze();
        access(1'b1, meas_readback_pkg::ADDR_CONTROL, 32'h1, 32'h0, 1'b0, "frz");
        access(1'b0, meas_readback_pkg::ADDR_CONTROL, 32'h0, 32'h1, 1'b0, "frz rd");
        sample(3'h1, 32'h12345678, 32'h0, 32'h0);
        sample(3'h0, 32'h0, 32'h0, 32'h0);
        access(1'b0, meas_readback_pkg::ADDR_PHASE_A, 32'h0, 32'h7ffffffe, 1'b0, "a frz");
        access(1'b1, meas_readback_pkg::ADDR_CONTROL, 32'h0, 32'h0, 1'b0, "thaw");
        sample(3'h1, 32'h12345678, 32'h0, 32'h0);
        sample(3'h0, 32'h0, 32'h0, 32'h0);
        access(1'b0, meas_readback_pkg::ADDR_PHASE_A, 32'h0, 32'h12345678, 1'b0, "a thaw");
    endtask

    // A second reset in mid-run must clear a stored word and the sense gain; the freeze bit is already thawed and is only read back as zero.
    task automatic test_rereset();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        access(1'b0, meas_readback_pkg::ADDR_PHASE_A, 32'h0, 32'h0, 1'b0, "a rerst");
        access(1'b0, meas_readback_pkg::ADDR_SENSE_GAIN, 32'h0, 32'h0, 1'b0, "sg rerst");
        access(1'b0, meas_readback_pkg::ADDR_CONTROL, 32'h0, 32'h0, 1'b0, "frz rerst");
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ********************************
    // Main sequence and watchdog
    // ********************************
    initial
    begin
        fails = 0;
        num_checks = 0;
        arst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        {upd_a, upd_b, upd_c} = 3'h0;
        {val_a, val_b, val_c} = 96'h0;
        {sg_code, sg_load, vg_code, vg_load} = 6'h0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        test_reset();
        test_phases();
        test_gains();
        test_writes();
        test_freeze();
        test_rereset();
        give_verdict();
    end

    // The whole run needs under 150 cycles; this margin only catches a hang.
    initial
    begin
        repeat (5000) @(posedge clock);
        fails++;
        give_verdict();
    end

endmodule
